// *** common/scan_pkg.sv ***
package scan_pkg;

  // Printed register offsets are word indices; byte address is four times.
  localparam logic [31:0] SCAN_STATE_IDX    = 32'h0B00_0192;
  localparam logic [31:0] SETTLE_IDLE_IDX   = 32'h0B00_0194;
  localparam logic [31:0] INTERVAL_IDX      = 32'h0B00_0196;
  localparam logic [31:0] CONTROL_IDX       = 32'h0B00_019A;
  localparam logic [31:0] SCAN_STATE_ADDR   = SCAN_STATE_IDX << 2;
  localparam logic [31:0] SETTLE_IDLE_ADDR  = SETTLE_IDLE_IDX << 2;
  localparam logic [31:0] INTERVAL_ADDR     = INTERVAL_IDX << 2;
  localparam logic [31:0] CONTROL_ADDR      = CONTROL_IDX << 2;

  localparam logic [15:0] REG_RESET         = 16'h0000;
  localparam logic [15:0] SETTLE_IDLE_MASK  = 16'h7C1F;
  localparam logic [15:0] INTERVAL_MASK     = 16'h03FF;
  localparam logic [15:0] CONTROL_MASK      = 16'h8003;

  localparam int SETTLE_LSB   = 0;
  localparam int IDLE_LSB     = 10;
  localparam int LINE_WAIT_W  = 5;
  localparam int GAP_W        = 10;
  localparam int RUN_BIT      = 0;
  localparam int AUTO_BIT     = 1;
  localparam int ENABLE_BIT   = 15;

  localparam int WAIT_W       = 11;
  localparam int LINES        = 8;

  localparam int TICK_NS      = 30000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_CYCLES  = TICK_NS / CLK_PERIOD_NS;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_STOPPED  = 2'b00,
    ST_WAIT_KEY = 2'b01,
    ST_SCAN     = 2'b10,
    ST_GAP      = 2'b11
  } seq_state_t;

endpackage

// *** common/wait_if.sv ***
`timescale 1ns/1ps
interface wait_if;
  logic                            start;
  logic [scan_pkg::WAIT_W-1:0]     ticks;
  logic                            tick;
  logic                            done;
  modport seq   (output start, ticks, tick, input done);
  modport timer (input start, ticks, tick, output done);
endinterface

// *** hw/tick_gen.sv ***
`timescale 1ns/1ps
module tick_gen #(
  parameter int CYCLES = scan_pkg::TICK_CYCLES
) (
  input  wire logic clk_in,   // System clock.
  input  wire logic rst_in,   // Synchronous reset.
  input  wire logic clear_in, // Restart the tick phase.
  output logic      tick_out  // One-cycle tick pulse.
);
  logic [15:0] cnt_r;

  // Restarting keeps each wait an exact multiple of the tick period.
  always_ff @(posedge clk_in)
  begin
    if (rst_in || clear_in)
    begin
      cnt_r    <= 16'h0000;
      tick_out <= 1'b0;
    end
    else if (cnt_r == 16'(CYCLES - 1))
    begin
      cnt_r    <= 16'h0000;
      tick_out <= 1'b1;
    end
    else
    begin
      cnt_r    <= cnt_r + 16'h0001;
      tick_out <= 1'b0;
    end
  end
endmodule

// *** hw/wait_timer.sv ***
`timescale 1ns/1ps
module wait_timer (
  input  wire logic clk_in, // System clock.
  input  wire logic rst_in, // Synchronous reset.
  wait_if.timer     w       // Start, length and done.
);
  logic [scan_pkg::WAIT_W-1:0] count_r;
  logic                        busy_r;
  logic                        done_r;

  assign w.done = done_r;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      count_r <= '0;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end
    else if (w.start)
    begin
      count_r <= w.ticks;
      busy_r  <= 1'b1;
      done_r  <= 1'b0;
    end
    else if (busy_r && w.tick)
    begin
      count_r <= count_r - 1'b1;
      busy_r  <= (count_r != 11'h001);
      done_r  <= (count_r == 11'h001);
    end
    else
      done_r <= 1'b0;
  end
endmodule

// *** hw/scan_timing.sv ***
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module scan_timing (
  input  wire logic        clk_in,                 // 10 MHz clock.
  input  wire logic        rst_in,                 // Sync reset, high.
  input  wire logic [31:0] s_axi_awaddr_in,        // Write address.
  input  wire logic        s_axi_awvalid_in,       // Write address valid.
  output logic             s_axi_awready_out,      // Write address ready.
  input  wire logic [31:0] s_axi_wdata_in,         // Write data.
  input  wire logic [3:0]  s_axi_wstrb_in,         // Write strobes.
  input  wire logic        s_axi_wvalid_in,        // Write data valid.
  output logic             s_axi_wready_out,       // Write data ready.
  output logic [1:0]       s_axi_bresp_out,        // Write response.
  output logic             s_axi_bvalid_out,       // Write response valid.
  input  wire logic        s_axi_bready_in,        // Write response ready.
  input  wire logic [31:0] s_axi_araddr_in,        // Read address.
  input  wire logic        s_axi_arvalid_in,       // Read address valid.
  output logic             s_axi_arready_out,      // Read address ready.
  output logic [31:0]      s_axi_rdata_out,        // Read data.
  output logic [1:0]       s_axi_rresp_out,        // Read response.
  output logic             s_axi_rvalid_out,       // Read data valid.
  input  wire logic        s_axi_rready_in,        // Read data ready.
  output logic [7:0]       matrix_drive_line_n_out, // Scan lines, low on.
  input  wire logic [7:0]  matrix_return_line_in,  // Return lines, pin.
  output logic [7:0]       scan_data_out,          // Sampled return bits.
  output logic [2:0]       scan_line_out,          // Line of scan_data.
  output logic             scan_data_valid_out,    // Sample pulse.
  output logic             scan_done_out,          // Full scan pulse.
  output logic [1:0]       sequencer_state_out     // Sequencer state.
);
  localparam logic [2:0] LAST_LINE = 3'(scan_pkg::LINES - 1);

  logic [15:0]             settle_idle_r;
  logic [15:0]             interval_r;
  logic [15:0]             control_r;
  logic                    aw_full_r;
  logic                    w_full_r;
  logic [31:0]             awaddr_r;
  logic [31:0]             wdata_r;
  logic [3:0]              wstrb_r;
  logic                    wr_fire;
  logic                    aw_full_nxt;
  logic                    w_full_nxt;
  logic [7:0]              ret_s1_r;
  logic [7:0]              ret_s2_r;
  scan_pkg::seq_state_t    state_r;
  logic                    idle_phase_r;
  logic [2:0]              line_r;
  logic                    all_up_r;
  logic                    start_r;
  logic [scan_pkg::WAIT_W-1:0] ticks_r;
  logic                    tick;
  logic [4:0]              settle_f;
  logic [4:0]              idle_f;
  logic [9:0]              gap_f;
  logic                    enable;
  logic                    run;
  logic                    auto;

  wait_if tmr ();

  assign tmr.start = start_r;
  assign tmr.ticks = ticks_r;
  assign tmr.tick  = tick;

  tick_gen #(.CYCLES(scan_pkg::TICK_CYCLES)) u_tick (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .clear_in (start_r),
    .tick_out (tick)
  );

  wait_timer u_timer (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .w      (tmr)
  );

  assign settle_f = settle_idle_r[scan_pkg::SETTLE_LSB +: 5];
  assign idle_f   = settle_idle_r[scan_pkg::IDLE_LSB +: 5];
  assign gap_f    = interval_r[scan_pkg::GAP_W-1:0];
  assign enable   = control_r[scan_pkg::ENABLE_BIT];
  assign run      = control_r[scan_pkg::RUN_BIT];
  assign auto     = control_r[scan_pkg::AUTO_BIT];

  // Byte lanes 0 and 1 carry the 16-bit registers; writable masks keep
  // reserved bits at zero.
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb,
                                        input logic [15:0] mask);
    logic [15:0] val;
    val = old;
    if (strb[0])
      val[7:0] = data[7:0];
    if (strb[1])
      val[15:8] = data[15:8];
    return val & mask;
  endfunction

  function automatic logic mapped(input logic [31:0] addr);
    return (addr == scan_pkg::SCAN_STATE_ADDR) ||
           (addr == scan_pkg::SETTLE_IDLE_ADDR) ||
           (addr == scan_pkg::INTERVAL_ADDR) ||
           (addr == scan_pkg::CONTROL_ADDR);
  endfunction

  // Write channel: address and data are taken in either order and the
  // register is written one cycle after both are held.
  assign wr_fire     = aw_full_r && w_full_r && !s_axi_bvalid_out;
  assign aw_full_nxt = (aw_full_r || (s_axi_awvalid_in && s_axi_awready_out))
                       && !wr_fire;
  assign w_full_nxt  = (w_full_r || (s_axi_wvalid_in && s_axi_wready_out))
                       && !wr_fire;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      aw_full_r         <= 1'b0;
      w_full_r          <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      awaddr_r          <= 32'h0000_0000;
      wdata_r           <= 32'h0000_0000;
      wstrb_r           <= 4'h0;
    end
    else
    begin
      aw_full_r         <= aw_full_nxt;
      w_full_r          <= w_full_nxt;
      s_axi_awready_out <= !aw_full_nxt;
      s_axi_wready_out  <= !w_full_nxt;
      if (s_axi_awvalid_in && s_axi_awready_out)
        awaddr_r <= s_axi_awaddr_in;
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        wdata_r <= s_axi_wdata_in;
        wstrb_r <= s_axi_wstrb_in;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= scan_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= mapped(awaddr_r) ? scan_pkg::RESP_OKAY
                                            : scan_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready_in)
      s_axi_bvalid_out <= 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      settle_idle_r <= scan_pkg::REG_RESET;
      interval_r    <= scan_pkg::REG_RESET;
      control_r     <= scan_pkg::REG_RESET;
    end
    else if (wr_fire)
    begin
      if (awaddr_r == scan_pkg::SETTLE_IDLE_ADDR)
        settle_idle_r <= merge(settle_idle_r, wdata_r, wstrb_r,
                               scan_pkg::SETTLE_IDLE_MASK);
      if (awaddr_r == scan_pkg::INTERVAL_ADDR)
        interval_r <= merge(interval_r, wdata_r, wstrb_r,
                            scan_pkg::INTERVAL_MASK);
      if (awaddr_r == scan_pkg::CONTROL_ADDR)
        control_r <= merge(control_r, wdata_r, wstrb_r,
                           scan_pkg::CONTROL_MASK);
    end
  end

  // Read channel: one read at a time, data one cycle after the address.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= scan_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rresp_out   <= mapped(s_axi_araddr_in) ? scan_pkg::RESP_OKAY
                                                    : scan_pkg::RESP_SLVERR;
      unique case (s_axi_araddr_in)
        scan_pkg::SCAN_STATE_ADDR:
          s_axi_rdata_out <= {30'h0000_0000, state_r};
        scan_pkg::SETTLE_IDLE_ADDR:
          s_axi_rdata_out <= {16'h0000, settle_idle_r};
        scan_pkg::INTERVAL_ADDR:
          s_axi_rdata_out <= {16'h0000, interval_r};
        scan_pkg::CONTROL_ADDR:
          s_axi_rdata_out <= {16'h0000, control_r};
        default:
          s_axi_rdata_out <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid_out && s_axi_rready_in)
    begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // Return lines come from pins; only the second stage is read.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ret_s1_r <= 8'hFF;
      ret_s2_r <= 8'hFF;
    end
    else
    begin
      ret_s1_r <= matrix_return_line_in;
      ret_s2_r <= ret_s1_r;
    end
  end

  // Zero line fields are forbidden to software; they still give one tick
  // here rather than hanging the sequencer.
  always_ff @(posedge clk_in)
  begin
    if (rst_in || !enable)
    begin
      state_r                 <= scan_pkg::ST_STOPPED;
      idle_phase_r            <= 1'b0;
      line_r                  <= 3'h0;
      all_up_r                <= 1'b1;
      start_r                 <= 1'b0;
      ticks_r                 <= '0;
      matrix_drive_line_n_out <= 8'hFF;
      scan_data_out           <= 8'hFF;
      scan_line_out           <= 3'h0;
      scan_data_valid_out     <= 1'b0;
      scan_done_out           <= 1'b0;
    end
    else
    begin
      start_r             <= 1'b0;
      scan_data_valid_out <= 1'b0;
      scan_done_out       <= 1'b0;
      unique case (state_r)
        scan_pkg::ST_STOPPED, scan_pkg::ST_WAIT_KEY:
        begin
          // Waiting drives every line low, so that any press pulls a return.
          matrix_drive_line_n_out <= (run && auto) ? 8'h00 : 8'hFF;
          if (!run)
            state_r <= scan_pkg::ST_STOPPED;
          else if (!auto || (state_r == scan_pkg::ST_WAIT_KEY &&
                             ret_s2_r != 8'hFF))
          begin
            state_r                 <= scan_pkg::ST_SCAN;
            line_r                  <= 3'h0;
            idle_phase_r            <= 1'b0;
            all_up_r                <= 1'b1;
            matrix_drive_line_n_out <= 8'hFE;
            start_r                 <= 1'b1;
            ticks_r                 <= 11'(settle_f) + 11'h001;
          end
          else
            state_r <= scan_pkg::ST_WAIT_KEY;
        end
        scan_pkg::ST_SCAN:
        begin
          if (tmr.done && !idle_phase_r)
          begin
            scan_data_out           <= ret_s2_r;
            scan_line_out           <= line_r;
            scan_data_valid_out     <= 1'b1;
            all_up_r                <= all_up_r && (ret_s2_r == 8'hFF);
            matrix_drive_line_n_out <= 8'hFF;
            idle_phase_r            <= 1'b1;
            start_r                 <= 1'b1;
            ticks_r                 <= 11'(idle_f) + 11'h001;
          end
          else if (tmr.done && line_r != LAST_LINE)
          begin
            line_r                  <= line_r + 3'h1;
            matrix_drive_line_n_out <= ~(8'h01 << (line_r + 3'h1));
            idle_phase_r            <= 1'b0;
            start_r                 <= 1'b1;
            ticks_r                 <= 11'(settle_f) + 11'h001;
          end
          else if (tmr.done)
          begin
            scan_done_out <= 1'b1;
            idle_phase_r  <= 1'b0;
            line_r        <= 3'h0;
            if (!run)
              state_r <= scan_pkg::ST_STOPPED;
            else if (auto && all_up_r)
              state_r <= scan_pkg::ST_WAIT_KEY;
            else if (gap_f == 10'h000)
            begin
              all_up_r                <= 1'b1;
              matrix_drive_line_n_out <= 8'hFE;
              start_r                 <= 1'b1;
              ticks_r                 <= 11'(settle_f) + 11'h001;
            end
            else
            begin
              state_r <= scan_pkg::ST_GAP;
              start_r <= 1'b1;
              ticks_r <= 11'(gap_f);
            end
          end
        end
        scan_pkg::ST_GAP:
        begin
          if (tmr.done && !run)
            state_r <= scan_pkg::ST_STOPPED;
          else if (tmr.done)
          begin
            state_r                 <= scan_pkg::ST_SCAN;
            all_up_r                <= 1'b1;
            matrix_drive_line_n_out <= 8'hFE;
            start_r                 <= 1'b1;
            ticks_r                 <= 11'(settle_f) + 11'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      sequencer_state_out <= 2'b00;
    else
      sequencer_state_out <= state_r;
  end

endmodule

// *** verification/key_matrix_model.sv ***
`timescale 1ns/1ps
module key_matrix_model (
  input  wire logic [7:0] drive_n_in, // Scan lines, low selects.
  input  wire logic       pressed_in, // Key held down.
  input  wire logic [2:0] row_in,     // Scan line of the key.
  input  wire logic [2:0] col_in,     // Return line of the key.
  output logic      [7:0] return_out  // Return lines.
);
  // Return lines have pull-ups, so an open key or an idle row reads high.
  always_comb
  begin
    return_out = 8'hFF;
    if (pressed_in && drive_n_in[row_in] == 1'h0)
      return_out[col_in] = 1'h0;
  end
endmodule

// *** verification/scan_timing_sva.sv ***
`timescale 1ns/1ps
module scan_timing_sva (
  input wire logic        clk_in,                  // Clock.
  input wire logic        rst_in,                  // Reset.
  input wire logic [1:0]  s_axi_bresp_out,         // Write response.
  input wire logic        s_axi_bvalid_out,        // Response valid.
  input wire logic        s_axi_bready_in,         // Response ready.
  input wire logic [31:0] s_axi_rdata_out,         // Read data.
  input wire logic        s_axi_rvalid_out,        // Read valid.
  input wire logic [7:0]  matrix_drive_line_n_out, // Scan lines.
  input wire logic [2:0]  scan_line_out,           // Sampled line.
  input wire logic        scan_data_valid_out,     // Sample pulse.
  input wire logic        scan_done_out,           // Scan end pulse.
  input wire logic [1:0]  sequencer_state_out      // Lagging state.
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_reset_quiet:
    assert property ($past(rst_in) |-> matrix_drive_line_n_out == 8'hFF
      && sequencer_state_out == 2'h0 && !s_axi_bvalid_out)
    else $error("Outputs not idle after reset.");
  // The state output lags one cycle, so it pairs with the previous lines.
  a_stop_lines_high:
    assert property (sequencer_state_out == 2'h0
      |-> $past(matrix_drive_line_n_out) == 8'hFF)
    else $error("Scan line driven while stopped.");
  a_gap_lines_high:
    assert property (sequencer_state_out == 2'h3
      |-> $past(matrix_drive_line_n_out) == 8'hFF)
    else $error("Scan line driven in the gap.");
  a_sample_in_scan:
    assert property (scan_data_valid_out |-> sequencer_state_out == 2'h2)
    else $error("Sample outside scanning state.");
  a_sample_releases:
    assert property (scan_data_valid_out |-> matrix_drive_line_n_out
      == 8'hFF && $past(matrix_drive_line_n_out) == ~(8'h01 << scan_line_out))
    else $error("Sample not taken from the driven line.");
  a_sample_pulse:
    assert property (scan_data_valid_out |=> !scan_data_valid_out)
    else $error("Sample pulse longer than one cycle.");
  a_done_last_line:
    assert property (scan_done_out |-> scan_line_out == 3'h7
      && $past(matrix_drive_line_n_out) == 8'hFF)
    else $error("Scan end not after the last idle wait.");
  a_upper_zero:
    assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0000)
    else $error("Upper read bits not zero.");
  a_resp_hold:
    assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("Write response dropped early.");
endmodule

bind scan_timing scan_timing_sva chk_u (
  .clk_in(clk_in), .rst_in(rst_in), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .matrix_drive_line_n_out(matrix_drive_line_n_out),
  .scan_line_out(scan_line_out), .scan_data_valid_out(scan_data_valid_out),
  .scan_done_out(scan_done_out), .sequencer_state_out(sequencer_state_out));

// *** verification/scan_timing_tb_top.sv ***
`timescale 1ns/1ps
module scan_timing_tb_top;
  localparam int TC = scan_pkg::TICK_CYCLES;
  logic        clk_in  = 1'h0;
  logic        rst_in  = 1'h1;
  logic [31:0] awaddr  = 32'h0;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] araddr  = 32'h0;
  logic        awvalid = 1'h0;
  logic        wvalid  = 1'h0;
  logic        bready  = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready  = 1'h0;
  logic        pressed = 1'h1;
  logic        awready, wready, bvalid, arready, rvalid, svalid, sdone;
  logic [1:0]  bresp, rresp, state;
  logic [31:0] rdata;
  logic [7:0]  drive_n, ret, sdata, last_drv;
  logic [2:0]  sline;
  logic [2:0]  exp_line = 3'h0;
  int          mismatches = 0;
  int          checks = 0;
  int          cyc = 0;
  int          t_fe, t_fd, t_v0, t_done, n0;
  int          n_val = 0;

  always #(scan_pkg::CLK_PERIOD_NS / 2) clk_in = ~clk_in;

  scan_timing dut_u (
    .clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .matrix_drive_line_n_out(drive_n),
    .matrix_return_line_in(ret), .scan_data_out(sdata),
    .scan_line_out(sline), .scan_data_valid_out(svalid),
    .scan_done_out(sdone), .sequencer_state_out(state));

  key_matrix_model mat_u (
    .drive_n_in(drive_n), .pressed_in(pressed), .row_in(3'h2),
    .col_in(3'h5), .return_out(ret));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic near(input string what, input int exp, input int got);
    checks++;
    if (got < exp - 2 || got > exp + 2)
    begin
      mismatches++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    mismatches++;
    $display("[ERR] %s expected answer seen timeout", what);
    finish_test;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge clk_in);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 100);
    bready <= 1'h0;
    if (n >= 100) give_up("bvalid");
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    int n;
    @(posedge clk_in);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 100);
    rready <= 1'h0;
    if (n >= 100) give_up("rvalid");
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk("rdata", exp, rdata);
  endtask

  // Selector 0 waits for a line pattern, 1 for the end-of-scan pulse.
  task automatic wait_for(input int sel, input logic [7:0] v, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end while (!(sel == 0 ? drive_n === v : sdone === 1'h1) && n < lim);
    if (n >= lim) give_up("wait");
  endtask

  // Time stamps let the main sequence judge waits without racing them.
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    last_drv <= drive_n;
    if (drive_n === 8'hFE && last_drv !== 8'hFE)
    begin
      t_fe <= cyc;
      exp_line <= 3'h0;
    end
    if (drive_n === 8'hFD && last_drv !== 8'hFD) t_fd <= cyc;
    if (sdone === 1'h1) t_done <= cyc;
    if (svalid === 1'h1)
    begin
      n_val <= n_val + 1;
      if (sline === 3'h0) t_v0 <= cyc;
      chk("scan_line", 32'(exp_line), 32'(sline));
      chk("scan_data", (pressed && exp_line == 3'h2) ? 32'hDF : 32'hFF,
          32'(sdata));
      exp_line <= exp_line + 3'h1;
    end
  end

  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'h0;
    rd(scan_pkg::SCAN_STATE_ADDR, 32'h0, scan_pkg::RESP_OKAY);
    rd(scan_pkg::SETTLE_IDLE_ADDR, 32'h0, scan_pkg::RESP_OKAY);
    rd(scan_pkg::INTERVAL_ADDR, 32'h0, scan_pkg::RESP_OKAY);
    wr(scan_pkg::SETTLE_IDLE_ADDR, 32'hFFFF_FFFF, scan_pkg::RESP_OKAY);
    rd(scan_pkg::SETTLE_IDLE_ADDR, 32'h7C1F, scan_pkg::RESP_OKAY);
    wr(scan_pkg::INTERVAL_ADDR, 32'hFFFF_FFFF, scan_pkg::RESP_OKAY);
    rd(scan_pkg::INTERVAL_ADDR, 32'h03FF, scan_pkg::RESP_OKAY);
    wr(scan_pkg::SCAN_STATE_ADDR, 32'hFFFF_FFFF, scan_pkg::RESP_OKAY);
    rd(scan_pkg::SCAN_STATE_ADDR, 32'h0, scan_pkg::RESP_OKAY);
    wr(32'h0000_0010, 32'h1, scan_pkg::RESP_SLVERR);
    rd(32'h0000_0010, 32'h0, scan_pkg::RESP_SLVERR);
    wr(scan_pkg::SETTLE_IDLE_ADDR, 32'h0801, scan_pkg::RESP_OKAY);
    wr(scan_pkg::INTERVAL_ADDR, 32'h0, scan_pkg::RESP_OKAY);
    wr(scan_pkg::CONTROL_ADDR, 32'h8001, scan_pkg::RESP_OKAY);
    rd(scan_pkg::SCAN_STATE_ADDR, 32'h2, scan_pkg::RESP_OKAY);
    wait_for(0, 8'hFB, 4000);
    near("settle", 2 * TC + 1, t_v0 - t_fe);
    near("idle", 3 * TC + 1, t_fd - t_v0);
    wait_for(1, 8'h0, 15000);
    repeat (4) @(posedge clk_in);
    near("no_gap", 1, t_fe - t_done);
    wr(scan_pkg::INTERVAL_ADDR, 32'h2, scan_pkg::RESP_OKAY);
    wait_for(1, 8'h0, 15000);
    rd(scan_pkg::SCAN_STATE_ADDR, 32'h3, scan_pkg::RESP_OKAY);
    wait_for(0, 8'hFE, 1000);
    repeat (2) @(posedge clk_in);
    near("gap", 2 * TC + 1, t_fe - t_done);
    wait_for(0, 8'hFD, 4000);
    wr(scan_pkg::CONTROL_ADDR, 32'h0001, scan_pkg::RESP_OKAY);
    repeat (2) @(posedge clk_in);
    chk("lines_off", 32'hFF, 32'(drive_n));
    rd(scan_pkg::SCAN_STATE_ADDR, 32'h0, scan_pkg::RESP_OKAY);
    n0 = n_val;
    repeat (1500) @(posedge clk_in);
    chk("pulses", n0, n_val);
    pressed <= 1'h0;
    wr(scan_pkg::CONTROL_ADDR, 32'h8003, scan_pkg::RESP_OKAY);
    rd(scan_pkg::SCAN_STATE_ADDR, 32'h1, scan_pkg::RESP_OKAY);
    pressed <= 1'h1;
    repeat (10) @(posedge clk_in);
    rd(scan_pkg::SCAN_STATE_ADDR, 32'h2, scan_pkg::RESP_OKAY);
    chk("state_out", 32'h2, 32'(state));
    finish_test;
  end
endmodule
